/* File: scr_readback_regs.sv */
// readback register bank of one serial channel with an axi4-lite slave
`default_nettype none
// Notes on behaviour
// RULE_01: loop sending high only while transmitting on loop
// RULE_02: outside monosync, on loop high only while inserted on loop
// RULE_03: monosync loop mode sets on loop when transmitting
// RULE_04: reserved loop status bits 3,2,0 read zero
// RULE_05: misc readback gives misc write or event enables
// RULE_06: low divisor readback returns stored low byte
// RULE_07: high divisor readback returns bits eight..fifteen reversed
// RULE_08: extended seven readback gives register or loop status
// RULE_09: event enable readback mirrors enables, reset F8
// RULE_10: fm two missed clocks latches flag, forces search
// RULE_11: reads change no stored state other than the sticky irq status, which a status read clears
module scr_readback_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_in_control,
  input  wire logic        loop_inserted,
  input  wire logic        tx_active,
  input  wire logic        pll_two_missed,
  output logic             pll_search,
  output logic             irq
);

  // write side storage
  logic [7:0] misc_txrx_control_write_r;  // mirrored when extended read on
  logic [7:0] rate_divisor_low_write_r;   // divisor low byte
  logic [7:0] rate_divisor_high_write_r;  // divisor high byte
  logic [7:0] extended_write_seven_r;     // extended seventh register
  logic [7:0] line_event_enable_write_r;  // line event enables
  logic [7:0] config_r;                   // mode and option bits
  // status
  logic       loop_send_r;                // transmitter holds the loop
  logic       on_loop_r;                  // channel inserted
  logic       two_miss_r;                 // latched missing clocks
  logic       search_r;                   // pll forced into search
  logic [scr_pkg::IRQ_W-1:0] irq_stat_r;  // sticky events
  logic [scr_pkg::IRQ_W-1:0] irq_mask_r;  // interrupt mask
  logic [scr_pkg::IRQ_W-1:0] irq_ev;      // event pulses
  // bus side
  logic [7:0]  aw_addr_r;                 // captured write address
  logic        aw_have_r;                 // address held
  logic [31:0] w_data_r;                  // captured write data
  logic [3:0]  w_strb_r;                  // captured strobes
  logic        w_have_r;                  // data held
  logic        do_write;                  // both halves present
  logic        rd_take;                   // read address taken
  logic        rd_hit;                    // decoded read hit
  logic [7:0]  rd_byte;                   // decoded read byte
  logic        loop_send_prev_r;          // edge history
  logic        on_loop_prev_r;            // edge history
  logic        two_miss_set;              // two clocks missing event
  logic        two_miss_clr;              // reset missing / search cmd
  logic        mode_loop;                 // loop mode
  logic        mode_mono;                 // monosync

  // derived mode bits
  assign mode_loop = config_r[scr_pkg::CFG_LOOP_BIT];
  assign mode_mono = config_r[scr_pkg::CFG_MONO_BIT];

  // status bytes built once, reused by several readbacks
  function automatic logic [7:0] loop_byte(input logic send, input logic onl,
                                           input logic miss);
    logic [7:0] b;
    b = 8'h00;
    b[scr_pkg::LOOP_SEND_BIT] = send;
    b[scr_pkg::ON_LOOP_BIT]   = onl;
    b[scr_pkg::TWO_MISS_BIT]  = miss;
    return b & scr_pkg::LOOP_STATUS_MASK; // RULE_04
  endfunction : loop_byte

  // axi handshakes: accept each half while not already holding one
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;
  assign do_write      = aw_have_r && w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_r <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_r <= 1'b0;
    end
  end

  // write response; readback offsets are read only and answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr_r)
        scr_pkg::OFF_MISC_WR, scr_pkg::OFF_DIV_LOW_WR, scr_pkg::OFF_DIV_HIGH_WR,
        scr_pkg::OFF_EXT_SEVEN_WR, scr_pkg::OFF_LINE_EVENT_WR, scr_pkg::OFF_CONFIG,
        scr_pkg::OFF_COMMAND, scr_pkg::OFF_IRQ_MASK: s_axi_bresp <= scr_pkg::RESP_OKAY;
        default: s_axi_bresp <= scr_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // stored write registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      misc_txrx_control_write_r <= 8'h00;
      rate_divisor_low_write_r  <= 8'h00;
      rate_divisor_high_write_r <= 8'h00;
      extended_write_seven_r    <= 8'h00;
      line_event_enable_write_r <= scr_pkg::LINE_EVENT_RESET; // RULE_09
      config_r                  <= 8'h00;
      irq_mask_r                <= '0;
    end else if (do_write && w_strb_r[0]) begin
      unique case (aw_addr_r)
        scr_pkg::OFF_MISC_WR:       misc_txrx_control_write_r <= w_data_r[7:0];
        scr_pkg::OFF_DIV_LOW_WR:    rate_divisor_low_write_r  <= w_data_r[7:0];
        scr_pkg::OFF_DIV_HIGH_WR:   rate_divisor_high_write_r <= w_data_r[7:0];
        scr_pkg::OFF_EXT_SEVEN_WR:  extended_write_seven_r    <= w_data_r[7:0];
        scr_pkg::OFF_LINE_EVENT_WR: begin
          // reserved enable bits never stored
          line_event_enable_write_r <= w_data_r[7:0] & scr_pkg::LINE_EVENT_MASK; // RULE_09
        end
        scr_pkg::OFF_CONFIG:        config_r   <= w_data_r[7:0];
        scr_pkg::OFF_IRQ_MASK:      irq_mask_r <= w_data_r[scr_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // command decode: reset missing clock or enter search
  assign two_miss_clr = do_write && w_strb_r[0] && (aw_addr_r == scr_pkg::OFF_COMMAND) &&
                        ((w_data_r[7:scr_pkg::CMD_LSB] == scr_pkg::CMD_RESET_MISSING) ||
                         (w_data_r[7:scr_pkg::CMD_LSB] == scr_pkg::CMD_ENTER_SEARCH));
  // only meaningful in fm with pll running
  assign two_miss_set = pll_two_missed && config_r[scr_pkg::CFG_FM_BIT] &&
                        config_r[scr_pkg::CFG_PLL_EN_BIT];

  // loop status; updated from channel inputs and config mode bits, never by reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_send_r <= 1'b0;
      on_loop_r   <= 1'b0;
    end else begin
      loop_send_r <= mode_loop && !mode_mono && tx_in_control && tx_active; // RULE_01
      // inserted in sdlc loop, or monosync loop once tx active
      on_loop_r   <= mode_loop && ((!mode_mono && loop_inserted) || // RULE_02
                                   (mode_mono && tx_active));      // RULE_03
    end
  end

  // two clocks missing latch and search request; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_miss_r <= 1'b0;
      search_r   <= 1'b0;
    end else if (two_miss_set) begin
      two_miss_r <= 1'b1; // RULE_10
      search_r   <= 1'b1; // RULE_10
    end else if (two_miss_clr) begin
      two_miss_r <= 1'b0;
      search_r   <= 1'b0;
    end else if (!config_r[scr_pkg::CFG_FM_BIT] || !config_r[scr_pkg::CFG_PLL_EN_BIT]) begin
      // flag reads zero outside fm or with pll off
      two_miss_r <= 1'b0;
      search_r   <= 1'b0;
    end
  end
  assign pll_search = search_r;

  // edge history for rising-edge events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_send_prev_r <= 1'b0;
      on_loop_prev_r   <= 1'b0;
    end else begin
      loop_send_prev_r <= loop_send_r;
      on_loop_prev_r   <= on_loop_r;
    end
  end

  assign irq_ev[scr_pkg::IRQ_TWO_MISS_BIT]  = two_miss_set && !two_miss_r;
  assign irq_ev[scr_pkg::IRQ_LOOP_SEND_BIT] = loop_send_r && !loop_send_prev_r;
  assign irq_ev[scr_pkg::IRQ_ON_LOOP_BIT]   = on_loop_r && !on_loop_prev_r;

  // sticky status, cleared by reading it; new events win over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (rd_take && s_axi_araddr == scr_pkg::OFF_IRQ_STATUS) begin
      irq_stat_r <= irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // read decode; pure mux, no state changes here
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      scr_pkg::OFF_LOOP_STATUS: rd_byte = loop_byte(loop_send_r, on_loop_r, two_miss_r); // RULE_04
      scr_pkg::OFF_MISC_CTRL: begin
        rd_byte = config_r[scr_pkg::CFG_EXT_READ_BIT] ? misc_txrx_control_write_r // RULE_05
                                                       : line_event_enable_write_r;
      end
      scr_pkg::OFF_DIV_LOW:  rd_byte = rate_divisor_low_write_r; // RULE_06
      scr_pkg::OFF_DIV_HIGH: begin
        // bit 7 carries divisor bit 8 ... bit 0 carries bit 15
        for (int i = 0; i < 8; i++) rd_byte[i] = rate_divisor_high_write_r[7-i]; // RULE_07
      end
      scr_pkg::OFF_EXT_SEVEN: begin
        rd_byte = config_r[scr_pkg::CFG_EXT_READ_BIT] ? extended_write_seven_r // RULE_08
                  : loop_byte(loop_send_r, on_loop_r, two_miss_r);
      end
      scr_pkg::OFF_LINE_EVENT: begin
        rd_byte = line_event_enable_write_r & scr_pkg::LINE_EVENT_MASK; // RULE_09
      end
      scr_pkg::OFF_MISC_WR:       rd_byte = misc_txrx_control_write_r;
      scr_pkg::OFF_DIV_LOW_WR:    rd_byte = rate_divisor_low_write_r;
      scr_pkg::OFF_DIV_HIGH_WR:   rd_byte = rate_divisor_high_write_r;
      scr_pkg::OFF_EXT_SEVEN_WR:  rd_byte = extended_write_seven_r;
      scr_pkg::OFF_LINE_EVENT_WR: rd_byte = line_event_enable_write_r;
      scr_pkg::OFF_CONFIG:        rd_byte = config_r;
      scr_pkg::OFF_COMMAND:       rd_byte = 8'h00;
      scr_pkg::OFF_IRQ_STATUS:    rd_byte = {5'h00, irq_stat_r};
      scr_pkg::OFF_IRQ_MASK:      rd_byte = {5'h00, irq_mask_r};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  // read data channel; one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= scr_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte}; // RULE_11
      s_axi_rresp  <= rd_hit ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_loop_send_cause: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
    loop_send_r |-> $past(tx_in_control && tx_active && mode_loop))
    else $error("loop sending without transmitter in control");
  a_on_loop_cause: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    $rose(on_loop_r) |-> $past(mode_loop && (loop_inserted || tx_active)))
    else $error("on loop set without cause");
  a_loop_mode_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    !$past(mode_loop) |-> !(loop_send_r || on_loop_r))
    else $error("loop status set outside loop mode");
  a_mono_on_loop: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    (mode_loop && mode_mono && tx_active) ##1 $stable(config_r) |-> on_loop_r)
    else $error("monosync loop did not set on loop");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    (s_axi_rvalid && $past(rd_take && s_axi_araddr == scr_pkg::OFF_LOOP_STATUS))
    |-> (s_axi_rdata[3:2] == 2'b00 && s_axi_rdata[0] == 1'b0))
    else $error("reserved loop status bit set");
  a_div_high_order: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_07
    (rd_take && s_axi_araddr == scr_pkg::OFF_DIV_HIGH)
    |=> s_axi_rdata[7] == $past(rate_divisor_high_write_r[0]))
    else $error("divisor high bit order wrong");
  a_div_low_value: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    (rd_take && s_axi_araddr == scr_pkg::OFF_DIV_LOW)
    |=> s_axi_rdata[7:0] == $past(rate_divisor_low_write_r))
    else $error("divisor low readback wrong");
  a_misc_select: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    (rd_take && s_axi_araddr == scr_pkg::OFF_MISC_CTRL && !config_r[scr_pkg::CFG_EXT_READ_BIT])
    |=> s_axi_rdata[7:0] == $past(line_event_enable_write_r))
    else $error("misc readback image wrong");
  a_ext_select: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    (rd_take && s_axi_araddr == scr_pkg::OFF_EXT_SEVEN && config_r[scr_pkg::CFG_EXT_READ_BIT])
    |=> s_axi_rdata[7:0] == $past(extended_write_seven_r))
    else $error("extended seven readback wrong");
  a_event_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    (line_event_enable_write_r & ~scr_pkg::LINE_EVENT_MASK) == 8'h00)
    else $error("reserved enable bit stored");
  a_two_miss_search: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    two_miss_set |=> (two_miss_r && search_r))
    else $error("missing clock not latched with search");
  a_search_cleared: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    (two_miss_clr && !two_miss_set) |=> !(two_miss_r || search_r))
    else $error("clearing command left missing clock latched");
  a_read_no_effect: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
    (rd_take && !do_write) |=> $stable(rate_divisor_low_write_r))
    else $error("read changed stored value");
  // interrupt status: events must land, a read clears all but new events
  a_event_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_ev != '0) |=> ((irq_stat_r & $past(irq_ev)) == $past(irq_ev)))
    else $error("event lost from sticky status");
  a_status_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && s_axi_araddr == scr_pkg::OFF_IRQ_STATUS) |=> irq_stat_r == $past(irq_ev))
    else $error("status read did not clear");

  c_write_done: cover property (@(posedge aclk) do_write ##[1:3] s_axi_bvalid);
  c_ext_read:   cover property (@(posedge aclk) rd_take && config_r[scr_pkg::CFG_EXT_READ_BIT]);
  c_two_miss:   cover property (@(posedge aclk) two_miss_set);
  c_irq_seen:   cover property (@(posedge aclk) irq);
  c_mono_loop:  cover property (@(posedge aclk) on_loop_r && mode_mono);

endmodule : scr_readback_regs
`default_nettype wire

/* File: scr_pkg.sv */
// register map, field positions and reset values for the channel readback block
`default_nettype none
package scr_pkg;
  // byte offsets of the readback registers on the bus
  localparam logic [7:0] OFF_LOOP_STATUS   = 8'h00; // loop status readback
  localparam logic [7:0] OFF_MISC_CTRL     = 8'h04; // misc control readback
  localparam logic [7:0] OFF_DIV_LOW       = 8'h08; // divisor low readback
  localparam logic [7:0] OFF_DIV_HIGH      = 8'h0C; // divisor high readback
  localparam logic [7:0] OFF_EXT_SEVEN     = 8'h10; // extended write seven readback
  localparam logic [7:0] OFF_LINE_EVENT    = 8'h14; // line event enable readback
  // write side registers that the readbacks mirror, then config, command and interrupt registers
  localparam logic [7:0] OFF_MISC_WR       = 8'h20; // misc tx/rx control write
  localparam logic [7:0] OFF_DIV_LOW_WR    = 8'h24; // divisor low write
  localparam logic [7:0] OFF_DIV_HIGH_WR   = 8'h28; // divisor high write
  localparam logic [7:0] OFF_EXT_SEVEN_WR  = 8'h2C; // extended write seven
  localparam logic [7:0] OFF_LINE_EVENT_WR = 8'h30; // line event enable write
  localparam logic [7:0] OFF_CONFIG        = 8'h34; // block configuration
  localparam logic [7:0] OFF_COMMAND       = 8'h38; // misc command write
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h3C; // sticky event status
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h40; // interrupt mask
  // loop status bit positions
  localparam int LOOP_SEND_BIT   = 4; // transmitter holds the loop
  localparam int ON_LOOP_BIT     = 1; // channel inserted on the loop
  localparam int TWO_MISS_BIT    = 6; // two clocks missing
  // configuration bit positions
  localparam int CFG_EXT_READ_BIT = 0; // extended read option
  localparam int CFG_LOOP_BIT     = 1; // loop mode select
  localparam int CFG_MONO_BIT     = 2; // monosync operation
  localparam int CFG_FM_BIT       = 3; // fm encoding
  localparam int CFG_PLL_EN_BIT   = 4; // phase lock enabled
  // command codes in the top three bits of the command register
  localparam logic [2:0] CMD_ENTER_SEARCH  = 3'h1;
  localparam logic [2:0] CMD_RESET_MISSING = 3'h2;
  localparam int         CMD_LSB           = 5;
  // event enable layout: valid bits and reset value; loop status valid bits
  localparam logic [7:0] LINE_EVENT_MASK   = 8'hFA;
  localparam logic [7:0] LINE_EVENT_RESET  = 8'hF8;
  localparam logic [7:0] LOOP_STATUS_MASK  = 8'hD2;
  // interrupt status bits
  localparam int IRQ_TWO_MISS_BIT  = 0; // two clocks missing set
  localparam int IRQ_LOOP_SEND_BIT = 1; // loop sending rose
  localparam int IRQ_ON_LOOP_BIT   = 2; // on loop rose
  localparam int IRQ_W             = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scr_pkg
`default_nettype wire

/* File: serial_channel_readback_regs_bench.sv */
// self-checking bench for the channel readback register bank
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module serial_channel_readback_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;                            // clock, sync reset
  logic [7:0]  awaddr, araddr;                           // bus addresses
  logic [31:0] wdata, rdata;                             // bus data
  logic [3:0]  wstrb;                                    // byte strobes
  logic        awvalid, awready, wvalid, wready;         // write request
  logic        bvalid, bready, arvalid, arready;         // write answer, read request
  logic        rvalid, rready;                           // read answer
  logic [1:0]  bresp, rresp, rs;                         // responses
  logic        tic, ins, txa, miss, srch, irq;           // channel side
  logic [31:0] v, d;                                     // stimulus, read data
  int          seed, fails, checked;                     // seed and counters
  scr_readback_regs DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_in_control(tic), .loop_inserted(ins), .tx_active(txa),
    .pll_two_missed(miss), .pll_search(srch), .irq(irq)
  );
  // free running 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // verdict and end of run, also reached from a hang
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // a bounded wait ran out
  task automatic hang();
    fails++;
    $display("bus wait ran out at %0t", $time);
    tally_and_finish();
  endtask : hang
  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [3:0] st,
                    output logic [1:0] r);
    bit got;
    got = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, dd};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (100) if (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) hang();
  endtask : wr
  // full strobe write, response ignored
  task automatic w(input logic [7:0] a, input logic [7:0] dd);
    logic [1:0] r;
    wr(a, dd, 4'hF, r);
  endtask : w
  // one read; rready held until rvalid seen
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    bit got;
    got = 0;
    q = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (100) if (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        q = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) hang();
  endtask : rd
  // read and compare whole word, upper bits must be zero
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    logic [1:0]  r;
    rd(a, q, r);
    `CHK(q, {24'h0, e})
  endtask : chk_rd
  // high divisor byte comes back in reversed bit order
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
  endfunction : rev8
  // loop status from config and line inputs; x21 case follows the transmitter
  function automatic logic [7:0] loop_exp(input logic [4:0] i);
    logic send, on;
    send = i[3] & !i[4] & i[0] & i[2];
    on = i[3] & (i[4] ? i[2] : i[1]);
    loop_exp = {3'h0, send, 2'h0, on, 1'b0};
  endfunction : loop_exp
  // one cycle of two missed clocks, then let the flag settle
  task automatic pulse();
    @(posedge aclk);
    miss <= 1'b1;
    @(posedge aclk);
    miss <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, tic, ins, txa, miss} = '0;
    fails = 0;
    checked = 0;
    seed = 32'h0021;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(scr_pkg::OFF_LINE_EVENT, scr_pkg::LINE_EVENT_RESET);
    chk_rd(scr_pkg::OFF_LOOP_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    $display("test reset done");
    // mirrored write registers, corner value first then random
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'hFF01_80FF : $random(seed);
      w(scr_pkg::OFF_DIV_LOW_WR, v[7:0]);
      w(scr_pkg::OFF_DIV_HIGH_WR, v[15:8]);
      w(scr_pkg::OFF_LINE_EVENT_WR, v[23:16]);
      w(scr_pkg::OFF_MISC_WR, v[31:24]);
      w(scr_pkg::OFF_EXT_SEVEN_WR, ~v[7:0]);
      w(scr_pkg::OFF_CONFIG, 8'h01);
      chk_rd(scr_pkg::OFF_DIV_LOW, v[7:0]);
      chk_rd(scr_pkg::OFF_DIV_HIGH, rev8(v[15:8]));
      chk_rd(scr_pkg::OFF_LINE_EVENT, v[23:16] & scr_pkg::LINE_EVENT_MASK);
      chk_rd(scr_pkg::OFF_MISC_CTRL, v[31:24]);
      chk_rd(scr_pkg::OFF_EXT_SEVEN, ~v[7:0]);
      w(scr_pkg::OFF_CONFIG, 8'h00);
      chk_rd(scr_pkg::OFF_MISC_CTRL, v[23:16] & scr_pkg::LINE_EVENT_MASK);
      chk_rd(scr_pkg::OFF_EXT_SEVEN, 8'h00);
      chk_rd(scr_pkg::OFF_DIV_LOW, v[7:0]);
    end
    $display("test mirrors done");
    // refused and empty writes, unmapped read
    wr(scr_pkg::OFF_DIV_LOW_WR, 8'h5A, 4'h0, rs);
    `CHK(rs, scr_pkg::RESP_OKAY)
    wr(scr_pkg::OFF_LINE_EVENT, 8'h00, 4'hF, rs);
    `CHK(rs, scr_pkg::RESP_SLVERR)
    chk_rd(scr_pkg::OFF_DIV_LOW, v[7:0]);
    chk_rd(scr_pkg::OFF_LINE_EVENT, v[23:16] & scr_pkg::LINE_EVENT_MASK);
    rd(8'h7C, d, rs);
    `CHK(rs, scr_pkg::RESP_SLVERR)
    `CHK(d, 32'h0)
    $display("test errors done");
    // every mix of loop mode, monosync and the three line inputs
    for (int i = 0; i < 32; i++) begin
      @(posedge aclk);
      tic <= i[0];
      ins <= i[1];
      txa <= i[2];
      w(scr_pkg::OFF_CONFIG, {5'h0, i[4], i[3], 1'b0});
      chk_rd(scr_pkg::OFF_LOOP_STATUS, loop_exp(i[4:0]));
      chk_rd(scr_pkg::OFF_EXT_SEVEN, loop_exp(i[4:0]));
    end
    @(posedge aclk);
    {tic, ins, txa} <= 3'h0;
    w(scr_pkg::OFF_CONFIG, 8'h00);
    $display("test loop done");
    // missed clocks: ignored without fm, latched and raising irq with it
    // both loop bits rose during the sweep, no missed clock yet
    chk_rd(scr_pkg::OFF_IRQ_STATUS, 8'h06);
    w(scr_pkg::OFF_IRQ_MASK, 8'h01);
    w(scr_pkg::OFF_CONFIG, 8'h10);
    pulse();
    chk_rd(scr_pkg::OFF_LOOP_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    w(scr_pkg::OFF_CONFIG, 8'h18);
    pulse();
    `CHK(srch, 1'b1)
    `CHK(irq, 1'b1)
    chk_rd(scr_pkg::OFF_LOOP_STATUS, 8'h40);
    chk_rd(scr_pkg::OFF_IRQ_STATUS, 8'h01);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    // both clearing commands
    for (int c = 1; c < 3; c++) begin
      pulse();
      chk_rd(scr_pkg::OFF_LOOP_STATUS, 8'h40);
      w(scr_pkg::OFF_COMMAND, {c[2:0], 5'h0});
      chk_rd(scr_pkg::OFF_LOOP_STATUS, 8'h00);
      `CHK(srch, 1'b0)
    end
    // masked event leaves irq low
    rd(scr_pkg::OFF_IRQ_STATUS, d, rs);
    w(scr_pkg::OFF_IRQ_MASK, 8'h00);
    pulse();
    `CHK(irq, 1'b0)
    // masked event is still recorded in the status
    chk_rd(scr_pkg::OFF_IRQ_STATUS, 8'h01);
    $display("test missed clocks done");
    // reset in mid-run returns every register to its reset value
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(scr_pkg::OFF_LINE_EVENT, scr_pkg::LINE_EVENT_RESET);
    chk_rd(scr_pkg::OFF_DIV_LOW, 8'h00);
    `CHK(srch, 1'b0)
    `CHK(irq, 1'b0)
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : serial_channel_readback_regs_bench
`default_nettype wire
